// *** rtl/ifs_pkg.sv ***
// Notes on behaviour
// - flash is 30 pages of 512 bytes; page erase addresses one page
// - erase leaves every byte of the erased region reading 8'hff
// - three erase kinds: mass erase of all flash, page erase of one page, option erase of the second option byte
// - data port supplies program byte and holds byte fetched by read
// - high and low address ports form the 16-bit target address
// - low three bits of op select choose idle, read, program, erase, option ops
// - first option byte never altered; option ops need address bit 0 set
// - operation starts on 46h then B9h to command register with enable set
// - command register read returns one id byte chosen by address low bit 0
// - control bit 7 gates any flash change
// - control bit 6 selects boot source after software reset
// - writing one to control bit 5 issues system reset, self clearing
// - software reset takes modify enable and boot select from its own control write; power-up clears them
// - wait field sets page erase stall: 43769, 21885, 10942, 5471 machine cycles
// - wait field sets program 240/120/60/30 and read 43/22/11/6 cycles
// - cpu held from trigger until the wait period expires
// - read data already in the data port when the cpu resumes
// - power-up boots programming memory if boot option 0 and size bits not 11
package ifs_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] OFS_DATA    = 3'h0;
    localparam logic [2:0] OFS_ADDR_HI = 3'h1;
    localparam logic [2:0] OFS_ADDR_LO = 3'h2;
    localparam logic [2:0] OFS_OP_SEL  = 3'h3;
    localparam logic [2:0] OFS_COMMAND = 3'h4;
    localparam logic [2:0] OFS_CONTROL = 3'h5;

    // control register field positions
    localparam int BIT_MODIFY_EN = 7;
    localparam int BIT_BOOT_SEL  = 6;
    localparam int BIT_SOFT_RST  = 5;

    // trigger key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'hb9;

    // identification bytes, values arbitrary
    localparam logic [7:0] ID_HIGH = 8'h5a;
    localparam logic [7:0] ID_LOW  = 8'h3c;

    // flash geometry and erase value
    localparam logic [4:0] PAGE_COUNT  = 5'h1e;
    localparam int         PAGE_SHIFT  = 9;
    localparam logic [7:0] ERASE_VALUE = 8'hff;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_WAIT = 3'h0;

    // stall timing: machine cycles per wait code, clocks per machine cycle
    localparam int CLKS_PER_MC = 12;
    localparam int PROG_MC0 = 240;
    localparam int PROG_MC1 = 120;
    localparam int PROG_MC2 = 60;
    localparam int PROG_MC3 = 30;
    localparam int READ_MC0 = 43;
    localparam int READ_MC1 = 22;
    localparam int READ_MC2 = 11;
    localparam int READ_MC3 = 6;
    localparam int ERASE_MC0 = 43769;
    localparam int ERASE_MC1 = 21885;
    localparam int ERASE_MC2 = 10942;
    localparam int ERASE_MC3 = 5471;
    localparam int TMR_W = 20;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [2:0] {
        OP_IDLE       = 3'b000,
        OP_READ       = 3'b001,
        OP_PROG       = 3'b010,
        OP_PAGE_ERASE = 3'b011,
        OP_MASS_ERASE = 3'b100,
        OP_OPT_READ   = 3'b101,
        OP_OPT_PROG   = 3'b110,
        OP_OPT_ERASE  = 3'b111
    } ifs_op_e;

    // command toward the flash array
    typedef struct packed {
        logic        valid;
        ifs_op_e     op;
        logic [15:0] addr;
        logic [4:0]  page;
        logic [7:0]  wdata;
        logic [7:0]  fill;
    } ifs_flash_cmd_s;

endpackage : ifs_pkg

// *** rtl/ifs_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module ifs_sequencer
    import ifs_pkg::*;
#(
    parameter logic [19:0] ERASE_CLKS0 = 20'(ERASE_MC0 * CLKS_PER_MC),
    parameter logic [19:0] ERASE_CLKS1 = 20'(ERASE_MC1 * CLKS_PER_MC),
    parameter logic [19:0] ERASE_CLKS2 = 20'(ERASE_MC2 * CLKS_PER_MC),
    parameter logic [19:0] ERASE_CLKS3 = 20'(ERASE_MC3 * CLKS_PER_MC)
) (
    input  wire logic           CLK_SYS,
    input  wire logic           NRST,
    input  wire logic [2:0]     REG_ADDR,
    input  wire logic [7:0]     REG_WDATA,
    input  wire logic           REG_WR,
    input  wire logic           REG_RD,
    output logic      [7:0]     REG_RDATA,
    input  wire logic           HARD_BOOT_OPTION,
    input  wire logic           PROG_AREA_SIZE_HI,
    input  wire logic           PROG_AREA_SIZE_LO,
    output logic                CPU_STALL,
    output logic                SOFT_RESET,
    output logic                BOOT_FROM_PROG,
    output ifs_flash_cmd_s      FLASH_CMD,
    input  wire logic [7:0]     FLASH_RDATA
);

    typedef struct packed {
        logic [7:0]     data;
        logic [7:0]     addr_hi;
        logic [7:0]     addr_lo;
        logic [2:0]     op_sel;
        logic           modify_en;
        logic           boot_sel;
        logic [2:0]     wait_sel;
        logic           armed;
        logic           busy;
        ifs_op_e        run_op;
        logic [TMR_W-1:0] timer;
        logic           soft_rst;
        logic           boot_prog;
        logic [1:0]     strap_cnt;
        logic [2:0]     pin_meta;
        logic [2:0]     pin_sync;
        logic [7:0]     rdata;
        ifs_flash_cmd_s cmd;
    } ifs_state_s;

    localparam ifs_state_s RST_STATE = '{
        data:      RST_BYTE,
        addr_hi:   RST_BYTE,
        addr_lo:   RST_BYTE,
        op_sel:    OP_IDLE,
        modify_en: 1'b0,
        boot_sel:  1'b0,
        wait_sel:  RST_WAIT,
        armed:     1'b0,
        busy:      1'b0,
        run_op:    OP_IDLE,
        timer:     '0,
        soft_rst:  1'b0,
        boot_prog: 1'b0,
        strap_cnt: 2'h0,
        pin_meta:  3'h0,
        pin_sync:  3'h0,
        rdata:     RST_BYTE,
        cmd:       '0
    };

    ifs_state_s state_ff;
    ifs_state_s nxt_state;

    // clock count of the stall for one operation and wait code
    function automatic logic [TMR_W-1:0] stall_clks(input ifs_op_e op, input logic [2:0] sel);
        int mc;
        logic [TMR_W-1:0] res;
        mc = 0;
        res = '0;
        unique case (op)
            OP_READ, OP_OPT_READ: begin
                unique case (sel)
                    3'h0:    mc = READ_MC0;
                    3'h1:    mc = READ_MC1;
                    3'h2:    mc = READ_MC2;
                    default: mc = READ_MC3;
                endcase
                res = TMR_W'(mc * CLKS_PER_MC);
            end
            OP_PROG, OP_OPT_PROG: begin
                unique case (sel)
                    3'h0:    mc = PROG_MC0;
                    3'h1:    mc = PROG_MC1;
                    3'h2:    mc = PROG_MC2;
                    default: mc = PROG_MC3;
                endcase
                res = TMR_W'(mc * CLKS_PER_MC);
            end
            OP_PAGE_ERASE, OP_MASS_ERASE, OP_OPT_ERASE: begin
                unique case (sel)
                    3'h0:    res = ERASE_CLKS0;
                    3'h1:    res = ERASE_CLKS1;
                    3'h2:    res = ERASE_CLKS2;
                    default: res = ERASE_CLKS3;
                endcase
            end
            OP_IDLE: res = '0;
        endcase
        return res;
    endfunction : stall_clks

    // whether a selected operation may reach the flash at this address
    function automatic logic op_allowed(input ifs_op_e op, input logic [15:0] addr);
        logic ok;
        ok = 1'b0;
        unique case (op)
            OP_IDLE:       ok = 1'b0;
            OP_READ, OP_PROG: ok = 1'b1;
            OP_PAGE_ERASE: ok = (addr[15:PAGE_SHIFT] < 7'(PAGE_COUNT));
            OP_MASS_ERASE: ok = 1'b1;
            OP_OPT_READ, OP_OPT_PROG, OP_OPT_ERASE: ok = addr[0];
        endcase
        return ok;
    endfunction : op_allowed

    logic [15:0] tgt_addr;
    ifs_op_e     sel_op;
    logic        wr_any;
    logic        soft_now;

    assign tgt_addr = {state_ff.addr_hi, state_ff.addr_lo};
    assign sel_op   = ifs_op_e'(state_ff.op_sel);
    // writes while the cpu is held cannot come from it, so they are dropped
    assign wr_any   = REG_WR && !state_ff.busy;
    assign soft_now = wr_any && (REG_ADDR == OFS_CONTROL) && REG_WDATA[BIT_SOFT_RST];

    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.cmd.valid = 1'b0;
        nxt_state.soft_rst = 1'b0;

        // boot pins cross into this clock through two flops
        nxt_state.pin_meta = {HARD_BOOT_OPTION, PROG_AREA_SIZE_HI, PROG_AREA_SIZE_LO};
        nxt_state.pin_sync = state_ff.pin_meta;

        // strap caught once the synchroniser has filled after power-up
        if (state_ff.strap_cnt < STRAP_SETTLE) begin
            nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
        end else if (state_ff.strap_cnt == STRAP_SETTLE) begin
            nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
            nxt_state.boot_prog = !state_ff.pin_sync[2]
                                  && (state_ff.pin_sync[1:0] != 2'b11);
        end

        // stall countdown; read data land on the same edge as release
        if (state_ff.busy) begin
            if (state_ff.timer == '0) begin
                nxt_state.busy = 1'b0;
                if (state_ff.run_op == OP_READ || state_ff.run_op == OP_OPT_READ) begin
                    nxt_state.data = FLASH_RDATA;
                end
            end else begin
                nxt_state.timer = state_ff.timer - TMR_W'(1);
            end
        end

        // register writes
        if (wr_any) begin
            unique case (REG_ADDR)
                OFS_DATA:    nxt_state.data = REG_WDATA;
                OFS_ADDR_HI: nxt_state.addr_hi = REG_WDATA;
                OFS_ADDR_LO: nxt_state.addr_lo = REG_WDATA;
                OFS_OP_SEL:  nxt_state.op_sel = REG_WDATA[2:0];
                OFS_COMMAND: begin
                    nxt_state.armed = 1'b0;
                    if (!state_ff.modify_en) begin
                        nxt_state.armed = 1'b0;
                    end else if (state_ff.armed && REG_WDATA == KEY_SECOND) begin
                        if (op_allowed(sel_op, tgt_addr)) begin
                            nxt_state.busy = 1'b1;
                            nxt_state.run_op = sel_op;
                            nxt_state.timer = stall_clks(sel_op, state_ff.wait_sel)
                                              - TMR_W'(1);
                            nxt_state.cmd.valid = 1'b1;
                            nxt_state.cmd.op = sel_op;
                            nxt_state.cmd.addr = tgt_addr;
                            nxt_state.cmd.page = tgt_addr[PAGE_SHIFT+4:PAGE_SHIFT];
                            nxt_state.cmd.wdata = state_ff.data;
                            nxt_state.cmd.fill = ERASE_VALUE;
                        end
                    end else if (REG_WDATA == KEY_FIRST) begin
                        nxt_state.armed = 1'b1;
                    end
                end
                OFS_CONTROL: begin
                    nxt_state.modify_en = REG_WDATA[BIT_MODIFY_EN];
                    nxt_state.boot_sel = REG_WDATA[BIT_BOOT_SEL];
                    nxt_state.wait_sel = REG_WDATA[2:0];
                    nxt_state.soft_rst = REG_WDATA[BIT_SOFT_RST];
                end
                default: ;
            endcase
        end

        // software reset clears data, address, op select, wait code and key state; enable and boot select come from the write
        if (soft_now) begin
            nxt_state.data = RST_BYTE;
            nxt_state.addr_hi = RST_BYTE;
            nxt_state.addr_lo = RST_BYTE;
            nxt_state.op_sel = OP_IDLE;
            nxt_state.wait_sel = RST_WAIT;
            nxt_state.armed = 1'b0;
            nxt_state.boot_prog = REG_WDATA[BIT_BOOT_SEL];
        end

        // read data one cycle after the strobe
        nxt_state.rdata = RST_BYTE;
        if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_DATA:    nxt_state.rdata = state_ff.data;
                OFS_ADDR_HI: nxt_state.rdata = state_ff.addr_hi;
                OFS_ADDR_LO: nxt_state.rdata = state_ff.addr_lo;
                OFS_OP_SEL:  nxt_state.rdata = {5'h00, state_ff.op_sel};
                OFS_COMMAND: nxt_state.rdata = state_ff.addr_lo[0] ? ID_LOW : ID_HIGH;
                OFS_CONTROL: nxt_state.rdata = {state_ff.modify_en, state_ff.boot_sel,
                                                3'h0, state_ff.wait_sel};
                default:     nxt_state.rdata = RST_BYTE;
            endcase
        end
    end

    // single state register; power-up reset only
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_ff <= RST_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // stall is a handshake toward the cpu, so it follows busy directly
    assign CPU_STALL      = state_ff.busy;
    assign SOFT_RESET     = state_ff.soft_rst;
    assign BOOT_FROM_PROG = state_ff.boot_prog;
    assign FLASH_CMD      = state_ff.cmd;
    assign REG_RDATA      = state_ff.rdata;

endmodule : ifs_sequencer
`default_nettype wire

// *** verif/ifs_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ifs_flash_model
    import ifs_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire ifs_flash_cmd_s cmd,
    output logic [7:0]          rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] opt_second;

    // array leaves the factory erased
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
        opt_second = 8'hff;
        rdata = 8'h00;
    end

    // programming only clears bits, so an unerased byte keeps stale zeros
    always @(posedge clk_sys) begin
        if (cmd.valid) begin
            case (cmd.op)
                OP_READ:       rdata <= mem[cmd.addr];
                OP_PROG:       mem[cmd.addr] <= mem[cmd.addr] & cmd.wdata;
                OP_PAGE_ERASE: begin
                    for (int i = 0; i < 512; i++) begin
                        mem[{cmd.page, 9'(i)}] <= cmd.fill;
                    end
                end
                OP_MASS_ERASE: begin
                    for (int i = 0; i < 65536; i++) begin
                        mem[i] <= cmd.fill;
                    end
                end
                OP_OPT_READ:   rdata <= opt_second;
                OP_OPT_PROG:   opt_second <= opt_second & cmd.wdata;
                OP_OPT_ERASE:  opt_second <= cmd.fill;
                default:       ;
            endcase
        end
    end
endmodule : ifs_flash_model
`default_nettype wire

// *** verif/ifs_sequencer_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module ifs_sequencer_asserts
    import ifs_pkg::*;
(
    input wire logic           CLK_SYS,
    input wire logic           NRST,
    input wire logic [2:0]     REG_ADDR,
    input wire logic [7:0]     REG_WDATA,
    input wire logic           REG_WR,
    input wire logic           REG_RD,
    input wire logic [7:0]     REG_RDATA,
    input wire logic           CPU_STALL,
    input wire logic           SOFT_RESET,
    input wire logic           BOOT_FROM_PROG,
    input wire ifs_flash_cmd_s FLASH_CMD
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // control write that asks for a software reset
    wire logic sw_rst = REG_WR && REG_ADDR == OFS_CONTROL && REG_WDATA[BIT_SOFT_RST] && !CPU_STALL;
    wire logic wsel   = REG_WDATA[BIT_BOOT_SEL];
    wire logic ers    = FLASH_CMD.valid
                        && FLASH_CMD.op inside {OP_PAGE_ERASE, OP_MASS_ERASE, OP_OPT_ERASE};
    wire logic key2   = REG_WR && REG_ADDR == OFS_COMMAND && REG_WDATA == KEY_SECOND;

    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside answer cycle");
    cmd_pulse_a: assert property (FLASH_CMD.valid |=> !FLASH_CMD.valid)
        else $error("flash command longer than one cycle");
    key_start_a: assert property ($rose(CPU_STALL) |-> $past(key2))
        else $error("stall began without second key byte");
    stall_cmd_a: assert property (FLASH_CMD.valid |-> $rose(CPU_STALL))
        else $error("command issued without stall start");
    stall_min_a: assert property ($rose(CPU_STALL) |-> CPU_STALL [*8])
        else $error("stall dropped too early");
    page_field_a: assert property (FLASH_CMD.valid |->
        FLASH_CMD.page == FLASH_CMD.addr[13:9]
        && !(FLASH_CMD.op == OP_PAGE_ERASE && FLASH_CMD.addr[15:9] > 7'h1d))
        else $error("bad page number in command");
    erase_fill_a: assert property (ers |-> FLASH_CMD.fill == ERASE_VALUE)
        else $error("erase fill not all ones");
    opt_addr_a: assert property (FLASH_CMD.valid && FLASH_CMD.op[2]
        && FLASH_CMD.op != OP_MASS_ERASE |-> FLASH_CMD.addr[0])
        else $error("option access to first option byte");
    idle_quiet_a: assert property (FLASH_CMD.valid |-> FLASH_CMD.op != OP_IDLE)
        else $error("idle op reached the array");
    sw_pulse_a: assert property (sw_rst |=> SOFT_RESET ##1 !SOFT_RESET)
        else $error("software reset pulse wrong");
    boot_sel_a: assert property (sw_rst |=> BOOT_FROM_PROG == $past(wsel))
        else $error("boot source not taken from control write");

    cover property (FLASH_CMD.valid && FLASH_CMD.op == OP_READ);
    cover property (FLASH_CMD.valid && FLASH_CMD.op == OP_PAGE_ERASE);
    cover property (SOFT_RESET);
endmodule : ifs_sequencer_asserts

bind ifs_sequencer ifs_sequencer_asserts i_ifs_sequencer_asserts (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CPU_STALL(CPU_STALL), .SOFT_RESET(SOFT_RESET),
    .BOOT_FROM_PROG(BOOT_FROM_PROG), .FLASH_CMD(FLASH_CMD));
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ifs_pkg::*;
    localparam int EC [4] = '{40, 30, 20, 10};
    localparam int PM [4] = '{PROG_MC0, PROG_MC1, PROG_MC2, PROG_MC3};
    localparam int RM [4] = '{READ_MC0, READ_MC1, READ_MC2, READ_MC3};
    logic           clk, nrst, we, re, hw, shi, slo, stall, srst, boot;
    logic [2:0]     ra;
    logic [7:0]     wd, rdata, frd, v;
    ifs_flash_cmd_s cmd;
    int             errors, num_checks, n;

    ifs_sequencer #(.ERASE_CLKS0(20'(EC[0])), .ERASE_CLKS1(20'(EC[1])), .ERASE_CLKS2(20'(EC[2])),
        .ERASE_CLKS3(20'(EC[3]))) i_ifs_sequencer (.CLK_SYS(clk), .NRST(nrst), .REG_ADDR(ra),
        .REG_WDATA(wd), .REG_WR(we), .REG_RD(re), .REG_RDATA(rdata), .HARD_BOOT_OPTION(hw),
        .PROG_AREA_SIZE_HI(shi), .PROG_AREA_SIZE_LO(slo), .CPU_STALL(stall), .SOFT_RESET(srst),
        .BOOT_FROM_PROG(boot), .FLASH_CMD(cmd), .FLASH_RDATA(frd));
    ifs_flash_model i_ifs_flash_model (.clk_sys(clk), .cmd(cmd), .rdata(frd));

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    // data is taken in the single answer cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        re <= 1'b1;
        ra <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // power-up reset with given straps, held 12 cycles
    task automatic por(input logic h, input logic s1, input logic s0);
        @(posedge clk);
        nrst <= 1'b0;
        hw <= h;
        shi <= s1;
        slo <= s0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : por

    // set up, trigger, and count stall cycles; zero means refused
    task automatic run(input logic [7:0] c, input logic [2:0] o, input logic [15:0] a,
                       input int len);
        wr(OFS_CONTROL, c);
        wr(OFS_OP_SEL, {5'h00, o});
        wr(OFS_ADDR_HI, a[15:8]);
        wr(OFS_ADDR_LO, a[7:0]);
        wr(OFS_COMMAND, KEY_FIRST);
        wr(OFS_COMMAND, KEY_SECOND);
        #1 n = 0;
        while (stall === 1'b1 && n < 40000) begin
            @(posedge clk);
            #1 n++;
        end
        chk(20'(n), 20'(len));
    endtask : run

    task automatic rdf(input logic [15:0] a, input logic [7:0] e);
        run(8'h83, OP_READ, a, RM[3] * CLKS_PER_MC);
        rd(OFS_DATA, v);
        chk(20'(v), 20'(e));
    endtask : rdf

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // watchdog, well beyond the expected run
    initial begin
        #300000;
        errors++;
        tally_and_finish;
    end

    initial begin
        {errors, num_checks, n} = '0;
        {nrst, we, re, hw, shi, slo, ra, wd} = '0;
        por(1'b0, 1'b0, 1'b1);
        chk(20'(boot), 20'h1);
        por(1'b1, 1'b0, 1'b0);
        chk(20'(boot), 20'h0);
        por(1'b0, 1'b1, 1'b1);
        chk(20'(boot), 20'h0);
        rd(OFS_CONTROL, v);
        chk(20'(v), 20'h0);
        wr(OFS_ADDR_LO, 8'h00);
        rd(OFS_COMMAND, v);
        chk(20'(v), 20'(ID_HIGH));
        wr(OFS_ADDR_LO, 8'h01);
        rd(OFS_COMMAND, v);
        chk(20'(v), 20'(ID_LOW));
        rd(3'h6, v);
        chk(20'(v), 20'h0);
        $display("test reset_and_id done");
        // refused triggers must not stall
        run(8'h03, OP_PROG, 16'h0400, 0);
        run(8'h83, OP_IDLE, 16'h0400, 0);
        run(8'h83, OP_OPT_PROG, 16'h0000, 0);
        run(8'h83, OP_PAGE_ERASE, 16'h3c00, 0);
        // legal page again, so only the broken key pair can hold the trigger back
        wr(OFS_ADDR_HI, 8'h04);
        wr(OFS_COMMAND, KEY_FIRST);
        wr(OFS_COMMAND, 8'h55);
        wr(OFS_COMMAND, KEY_SECOND);
        #1 chk(20'(stall), 20'h0);
        $display("test refused done");
        // erase before program; wait codes 000 to 011
        run(8'h83, OP_PAGE_ERASE, 16'h0600, EC[3]);
        wr(OFS_DATA, 8'h12);
        run(8'h83, OP_PROG, 16'h0605, PM[3] * CLKS_PER_MC);
        for (int w = 0; w < 4; w++) begin
            run({5'h10, 3'(w)}, OP_PAGE_ERASE, 16'h0400, EC[w]);
            wr(OFS_DATA, 8'ha5);
            run({5'h10, 3'(w)}, OP_PROG, 16'h0405, PM[w] * CLKS_PER_MC);
            run({5'h10, 3'(w)}, OP_READ, 16'h0405, RM[w] * CLKS_PER_MC);
            rd(OFS_DATA, v);
            chk(20'(v), 20'ha5);
        end
        run(8'h83, OP_PAGE_ERASE, 16'h0400, EC[3]);
        rdf(16'h0405, 8'hff);
        rdf(16'h0605, 8'h12);
        run(8'h83, OP_MASS_ERASE, 16'h0000, EC[3]);
        rdf(16'h0605, 8'hff);
        // wait codes above 011 run with the shortest stall
        wr(OFS_DATA, 8'h3e);
        run(8'h86, OP_PROG, 16'h0605, PM[3] * CLKS_PER_MC);
        run(8'h87, OP_READ, 16'h0605, RM[3] * CLKS_PER_MC);
        rd(OFS_DATA, v);
        chk(20'(v), 20'h3e);
        $display("test flash_ops done");
        // second option byte erase, program, read
        run(8'h83, OP_OPT_ERASE, 16'h0001, EC[3]);
        wr(OFS_DATA, 8'h96);
        run(8'h83, OP_OPT_PROG, 16'h0001, PM[3] * CLKS_PER_MC);
        run(8'h83, OP_OPT_READ, 16'h0001, RM[3] * CLKS_PER_MC);
        rd(OFS_DATA, v);
        chk(20'(v), 20'h96);
        $display("test option done");
        // software reset into programming code, then back
        wr(OFS_CONTROL, 8'he3);
        #1 chk(20'(srst), 20'h1);
        repeat (2) @(posedge clk);
        #1 chk(20'(boot), 20'h1);
        rd(OFS_CONTROL, v);
        chk(20'(v), 20'hc0);
        rd(OFS_DATA, v);
        chk(20'(v), 20'h0);
        wr(OFS_CONTROL, 8'h20);
        repeat (2) @(posedge clk);
        #1 chk(20'(boot), 20'h0);
        rd(OFS_CONTROL, v);
        chk(20'(v), 20'h0);
        $display("test soft_reset done");
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
